// file: debug_reset_seq.v
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "debug_reset_seq_regs.vh"

module debug_reset_seq #(
  parameter POLL_LIMIT = 65536
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  // Software register port.
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Target debug register access port, one access outstanding.
  output reg dbg_req_out,
  output reg dbg_write_out,
  output reg [31:0] dbg_addr_out,
  output reg [31:0] dbg_wdata_out,
  input wire dbg_ack_in,
  input wire [31:0] dbg_rdata_in,
  // Target reset line and serial debug clock divider.
  output reg target_reset_n_out,
  output reg [15:0] swd_clk_div_out,
  // Sequencer status.
  output reg busy_out,
  output reg halted_out,
  output reg error_out
);

  // ===================================================================
  // States, one-hot.
  // ===================================================================
  localparam [12:0] ST_IDLE = 13'h0001;
  localparam [12:0] ST_PIN_LOW = 13'h0002;
  localparam [12:0] ST_WR_VC = 13'h0004;
  localparam [12:0] ST_WR_HALT = 13'h0008;
  localparam [12:0] ST_PIN_REL = 13'h0010;
  localparam [12:0] ST_WR_SYSRST = 13'h0020;
  localparam [12:0] ST_POLL_HI = 13'h0040;
  localparam [12:0] ST_POLL_LO = 13'h0080;
  localparam [12:0] ST_CLR_VC = 13'h0100;
  localparam [12:0] ST_BOOT_WAIT = 13'h0200;
  localparam [12:0] ST_CHK_HALT = 13'h0400;
  localparam [12:0] ST_WR_WD = 13'h0800;
  localparam [12:0] ST_FINISH = 13'h1000;

  localparam [31:0] HOLD_CYCLES = `SEQ_RESET_HOLD_CYCLES;

  localparam [31:0] SWD_MAX_DIV_W = `SEQ_SWD_MAX_DIV;
  localparam [15:0] SWD_MAX_DIV = SWD_MAX_DIV_W[15:0];
  localparam [31:0] POLL_LIMIT_W = POLL_LIMIT;

  // ===================================================================
  // Registers.
  // ===================================================================
  reg [12:0] state_reg; // Current sequencer state.
  reg [3:0] strat_reg; // Strategy number software selected.
  reg [3:0] run_strat_reg; // Strategy latched at start.
  reg [31:0] wd_addr_reg; // Target address of the watchdog disable write.
  reg [31:0] wd_data_reg; // Value that disables the watchdog.
  reg [31:0] boot_wait_reg; // Cycles allowed for the bootloader or kernel.
  reg [15:0] clk_div_reg; // Software's serial clock divider.
  reg [31:0] count_reg; // Hold, wait and poll counter.
  reg pend_reg; // A debug access is in flight.
  reg unsupported_reg; // Last start named a strategy we do not run.
  reg timeout_reg; // Last run gave up polling.

  wire start_w = reg_wr_in && (reg_addr_in == `SEQ_CTRL_OFFSET) &&
                 reg_wdata_in[`SEQ_CTRL_START_BIT];
  wire [3:0] start_strat_w = reg_wdata_in[`SEQ_CTRL_STRAT_MSB:`SEQ_CTRL_STRAT_LSB];
  wire sticky_w = dbg_rdata_in[`TGT_RESET_STICKY_BIT];
  wire halted_w = dbg_rdata_in[`TGT_HALTED_BIT];
  // Which strategies run a bootloader first and which write the watchdog.
  wire boot_w = (run_strat_reg == 4'h4) || (run_strat_reg == 4'h7) ||
                (run_strat_reg == 4'h9);
  wire wd_w = (run_strat_reg == 4'h6) || (run_strat_reg == 4'h9) ||
              (run_strat_reg == 4'hA);
  wire known_w = (start_strat_w == 4'h0) || (start_strat_w == 4'h3) ||
                 ((start_strat_w >= 4'h4) && (start_strat_w <= 4'hA));
  wire poll_over_w = (count_reg >= POLL_LIMIT_W);

  // ===================================================================
  // Software register writes.
  // ===================================================================
  // Only the strategy is latched at start; the other registers are used live,
  // so a write during a run takes effect in that same run.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strat_reg <= `SEQ_STRAT_RESET;
      wd_addr_reg <= `SEQ_WD_ADDR_RESET;
      wd_data_reg <= `SEQ_WD_DATA_RESET;
      boot_wait_reg <= `SEQ_BOOT_WAIT_RESET;
      clk_div_reg <= `SEQ_CLK_DIV_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SEQ_CTRL_OFFSET: strat_reg <= start_strat_w;
        `SEQ_WD_ADDR_OFFSET: wd_addr_reg <= reg_wdata_in;
        `SEQ_WD_DATA_OFFSET: wd_data_reg <= reg_wdata_in;
        `SEQ_BOOT_WAIT_OFFSET: boot_wait_reg <= reg_wdata_in;
        `SEQ_CLK_DIV_OFFSET: clk_div_reg <= reg_wdata_in[15:0];
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
  end

  // ===================================================================
  // Software register reads, data one cycle after the strobe.
  // ===================================================================
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SEQ_CTRL_OFFSET: reg_rdata_out <= {24'h000000, strat_reg, 4'h0};
        `SEQ_STATUS_OFFSET: reg_rdata_out <= {3'h0, state_reg, 11'h000,
          timeout_reg, unsupported_reg, error_out, halted_out, busy_out};
        `SEQ_WD_ADDR_OFFSET: reg_rdata_out <= wd_addr_reg;
        `SEQ_WD_DATA_OFFSET: reg_rdata_out <= wd_data_reg;
        `SEQ_BOOT_WAIT_OFFSET: reg_rdata_out <= boot_wait_reg;
        `SEQ_CLK_DIV_OFFSET: reg_rdata_out <= {16'h0000, swd_clk_div_out};
        default: reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // ===================================================================
  // Serial clock divider.
  // ===================================================================
  // The watchdog-racing strategy needs a fast serial clock, so the divider
  // is clamped to the slowest setting that still reaches the minimum rate.
  // The clamp starts on the start edge, so no access of that run goes out
  // slow; other runs use software's choice as is.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      swd_clk_div_out <= `SEQ_CLK_DIV_RESET;
    end else if ((clk_div_reg > SWD_MAX_DIV) && ((busy_out && (run_strat_reg == 4'h9)) ||
                 (start_w && !busy_out && (start_strat_w == 4'h9)))) begin
      swd_clk_div_out <= SWD_MAX_DIV;
    end else begin
      swd_clk_div_out <= clk_div_reg;
    end
  end

  // ===================================================================
  // Sequencer.
  // ===================================================================
  // Each access state raises a request, holds it until the target port
  // acknowledges, then moves on. Read states look at the data that comes
  // with the acknowledge.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      run_strat_reg <= 4'h0;
      count_reg <= 32'h00000000;
      pend_reg <= 1'b0;
      dbg_req_out <= 1'b0;
      dbg_write_out <= 1'b0;
      dbg_addr_out <= 32'h00000000;
      dbg_wdata_out <= 32'h00000000;
      target_reset_n_out <= 1'b1;
      busy_out <= 1'b0;
      halted_out <= 1'b0;
      error_out <= 1'b0;
      unsupported_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          count_reg <= 32'h00000000;
          if (start_w) begin
            halted_out <= 1'b0;
            error_out <= !known_w;
            unsupported_reg <= !known_w;
            timeout_reg <= 1'b0;
            run_strat_reg <= start_strat_w;
            if (known_w) begin
              busy_out <= 1'b1;
              if (start_strat_w == 4'h3) begin
                state_reg <= ST_PIN_LOW;
              end else if ((start_strat_w == 4'h4) || (start_strat_w == 4'h7) ||
                           (start_strat_w == 4'h9)) begin
                state_reg <= ST_WR_SYSRST;
              end else begin
                state_reg <= ST_WR_VC;
              end
            end
          end
        end

        ST_PIN_LOW: begin
          // The line goes low here and stays low until after the catch and
          // halt request are written, so the core never runs a cycle.
          target_reset_n_out <= 1'b0;
          count_reg <= count_reg + 32'h00000001;
          if (count_reg + 32'h00000001 >= HOLD_CYCLES) begin
            count_reg <= 32'h00000000;
            state_reg <= ST_WR_VC;
          end
        end

        ST_WR_VC: begin
          if (!pend_reg) begin
            pend_reg <= 1'b1;
            dbg_req_out <= 1'b1;
            dbg_write_out <= 1'b1;
            dbg_addr_out <= `TGT_DEBUG_EXC_MON_CTRL_ADDR;
            dbg_wdata_out <= `TGT_VECTOR_CATCH_SET_VALUE;
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            state_reg <= (run_strat_reg == 4'h3) ? ST_WR_HALT : ST_WR_SYSRST;
          end
        end

        ST_WR_HALT: begin
          if (!pend_reg) begin
            pend_reg <= 1'b1;
            dbg_req_out <= 1'b1;
            dbg_write_out <= 1'b1;
            dbg_addr_out <= `TGT_HALT_CTRL_STATUS_ADDR;
            dbg_wdata_out <= `TGT_HALT_REQUEST_VALUE;
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            state_reg <= (run_strat_reg == 4'h3) ? ST_PIN_REL : ST_CHK_HALT;
          end
        end

        ST_PIN_REL: begin
          // Connection done under reset; now let the target come out of it.
          target_reset_n_out <= 1'b1;
          state_reg <= ST_POLL_LO;
        end

        ST_WR_SYSRST: begin
          if (!pend_reg) begin
            pend_reg <= 1'b1;
            dbg_req_out <= 1'b1;
            dbg_write_out <= 1'b1;
            dbg_addr_out <= `TGT_APP_INT_RESET_CTRL_ADDR;
            dbg_wdata_out <= `TGT_SYS_RESET_REQ_VALUE;
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            count_reg <= 32'h00000000;
            state_reg <= ST_POLL_HI;
          end
        end

        ST_POLL_HI, ST_POLL_LO, ST_CHK_HALT: begin
          // A target that never answers as hoped must not hang the probe.
          if (!pend_reg) begin
            if (poll_over_w) begin
              error_out <= 1'b1;
              timeout_reg <= 1'b1;
              state_reg <= ST_FINISH;
            end else begin
              pend_reg <= 1'b1;
              dbg_req_out <= 1'b1;
              dbg_write_out <= 1'b0;
              dbg_addr_out <= `TGT_HALT_CTRL_STATUS_ADDR;
              dbg_wdata_out <= 32'h00000000;
            end
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            count_reg <= count_reg + 32'h00000001;
            if ((state_reg == ST_POLL_HI) && sticky_w) begin
              count_reg <= 32'h00000000;
              state_reg <= ST_POLL_LO;
            end else if ((state_reg == ST_POLL_LO) && !sticky_w) begin
              count_reg <= 32'h00000000;
              state_reg <= boot_w ? ST_BOOT_WAIT : ST_CLR_VC;
            end else if ((state_reg == ST_CHK_HALT) && halted_w) begin
              state_reg <= wd_w ? ST_WR_WD : ST_FINISH;
              halted_out <= !wd_w;
            end
          end
        end

        ST_CLR_VC: begin
          if (!pend_reg) begin
            pend_reg <= 1'b1;
            dbg_req_out <= 1'b1;
            dbg_write_out <= 1'b1;
            dbg_addr_out <= `TGT_DEBUG_EXC_MON_CTRL_ADDR;
            dbg_wdata_out <= `TGT_VECTOR_CATCH_CLR_VALUE;
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            count_reg <= 32'h00000000;
            state_reg <= ST_CHK_HALT;
          end
        end

        ST_BOOT_WAIT: begin
          // Give the bootloader or kernel its time, then stop the core
          // before the application's first instruction.
          count_reg <= count_reg + 32'h00000001;
          if (count_reg >= boot_wait_reg) begin
            count_reg <= 32'h00000000;
            state_reg <= ST_WR_HALT;
          end
        end

        ST_WR_WD: begin
          // The watchdog keeps counting while halted, so this write goes out
          // right after the halt is seen.
          if (!pend_reg) begin
            pend_reg <= 1'b1;
            dbg_req_out <= 1'b1;
            dbg_write_out <= 1'b1;
            dbg_addr_out <= wd_addr_reg;
            dbg_wdata_out <= wd_data_reg;
          end else if (dbg_ack_in) begin
            pend_reg <= 1'b0;
            dbg_req_out <= 1'b0;
            halted_out <= 1'b1;
            state_reg <= ST_FINISH;
          end
        end

        ST_FINISH: begin
          busy_out <= 1'b0;
          target_reset_n_out <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          pend_reg <= 1'b0;
          dbg_req_out <= 1'b0;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: debug_reset_seq_regs.vh
`ifndef DEBUG_RESET_SEQ_REGS_VH
`define DEBUG_RESET_SEQ_REGS_VH

// =====================================================================
// Software register offsets (byte addresses, one word each).
// =====================================================================
`define SEQ_CTRL_OFFSET 8'h00
`define SEQ_STATUS_OFFSET 8'h04
`define SEQ_WD_ADDR_OFFSET 8'h08
`define SEQ_WD_DATA_OFFSET 8'h0C
`define SEQ_BOOT_WAIT_OFFSET 8'h10
`define SEQ_CLK_DIV_OFFSET 8'h14

// Control register fields.
`define SEQ_CTRL_START_BIT 0
`define SEQ_CTRL_STRAT_LSB 4
`define SEQ_CTRL_STRAT_MSB 7

// Reset values of the software registers.
`define SEQ_STRAT_RESET 4'h0
`define SEQ_WD_ADDR_RESET 32'h00000000
`define SEQ_WD_DATA_RESET 32'h00000000
`define SEQ_BOOT_WAIT_RESET 32'h00000400
`define SEQ_CLK_DIV_RESET 16'h0009

// =====================================================================
// Target debug register map and values.
// =====================================================================
`define TGT_HALT_CTRL_STATUS_ADDR 32'hE000EDF0
`define TGT_DEBUG_EXC_MON_CTRL_ADDR 32'hE000EDFC
`define TGT_APP_INT_RESET_CTRL_ADDR 32'hE000ED0C
`define TGT_HALT_REQUEST_VALUE 32'hA05F0003
`define TGT_SYS_RESET_REQ_VALUE 32'h05FA0004
`define TGT_VECTOR_CATCH_SET_VALUE 32'h00000001
`define TGT_VECTOR_CATCH_CLR_VALUE 32'h00000000
`define TGT_RESET_STICKY_BIT 25
`define TGT_HALTED_BIT 17

// =====================================================================
// Timing.
// =====================================================================
`define SEQ_CLK_MHZ 200
`define SEQ_RESET_HOLD_NS 1000
`define SEQ_RESET_HOLD_CYCLES ((`SEQ_RESET_HOLD_NS * `SEQ_CLK_MHZ + 999) / 1000)
`define SEQ_SWD_MIN_HZ 1000000
// Divider gives swd clock = sys / (2 * (div + 1)); largest div meeting the minimum.
`define SEQ_SWD_MAX_DIV ((`SEQ_CLK_MHZ * 1000000) / (2 * `SEQ_SWD_MIN_HZ) - 1)

`endif

// file: debug_reset_seq_checker.sv
`timescale 1ns/100ps
`include "debug_reset_seq_regs.vh"
// =====================================================================
// Port-level checker for the reset strategy sequencer.
// =====================================================================
module debug_reset_seq_checker #(
  parameter POLL_LIMIT = 65536
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire dbg_req_out,
  input wire dbg_write_out,
  input wire [31:0] dbg_addr_out,
  input wire [31:0] dbg_wdata_out,
  input wire dbg_ack_in,
  input wire [31:0] dbg_rdata_in,
  input wire target_reset_n_out,
  input wire [15:0] swd_clk_div_out,
  input wire busy_out,
  input wire halted_out,
  input wire error_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // A start is only taken while idle, so it is qualified by busy.
  wire start = reg_wr_in && reg_addr_in == `SEQ_CTRL_OFFSET && reg_wdata_in[0] && !busy_out;
  wire [3:0] st = reg_wdata_in[7:4];
  wire bad_st = st == 4'h1 || st == 4'h2 || st > 4'hA;
  reg [3:0] strat_reg; // Strategy last written by software.
  reg sticky_reg; // Reset sticky bit from the last status read.
  reg wd_reg; // Watchdog write seen in this run.
  reg [31:0] wd_addr_reg; // Watchdog address programmed by software.
  wire catch_st = strat_reg == 4'h0 || strat_reg == 4'h5 || strat_reg == 4'h6 ||
                  strat_reg == 4'h8 || strat_reg == 4'hA;
  wire wd_st = strat_reg == 4'h6 || strat_reg == 4'h9 || strat_reg == 4'hA;
  wire acked = dbg_req_out && dbg_ack_in;
  // Shadow state follows software writes and completed debug accesses.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strat_reg <= 4'h0;
      sticky_reg <= 1'b0;
      wd_reg <= 1'b0;
      wd_addr_reg <= 32'h00000000;
    end else begin
      if (reg_wr_in && reg_addr_in == `SEQ_CTRL_OFFSET) strat_reg <= reg_wdata_in[7:4];
      if (reg_wr_in && reg_addr_in == `SEQ_WD_ADDR_OFFSET) wd_addr_reg <= reg_wdata_in;
      if (acked && !dbg_write_out && dbg_addr_out == `TGT_HALT_CTRL_STATUS_ADDR) begin
        sticky_reg <= dbg_rdata_in[`TGT_RESET_STICKY_BIT];
      end
      if (start) begin
        wd_reg <= 1'b0;
      end else if (acked && dbg_write_out && dbg_addr_out == wd_addr_reg) begin
        wd_reg <= 1'b1;
      end
    end
  end
  property p_pin_hold;
    $fell(target_reset_n_out) |-> !target_reset_n_out [*8];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("reset pulse too short");
  property p_pin_in_run;
    !target_reset_n_out |-> busy_out;
  endproperty
  a_pin_in_run: assert property (p_pin_in_run) else $error("reset low while idle");
  property p_catch_first;
    start && (st == 4'h0 || st == 4'h8) |-> ##[1:4] (dbg_req_out && dbg_write_out &&
      dbg_addr_out == `TGT_DEBUG_EXC_MON_CTRL_ADDR && dbg_wdata_out == 32'h00000001);
  endproperty
  a_catch_first: assert property (p_catch_first) else $error("catch not armed first");
  property p_sysrst_next;
    acked && dbg_write_out && dbg_addr_out == `TGT_DEBUG_EXC_MON_CTRL_ADDR &&
      dbg_wdata_out[0] && catch_st |-> ##[1:4] (dbg_req_out && dbg_write_out &&
      dbg_addr_out == `TGT_APP_INT_RESET_CTRL_ADDR && dbg_wdata_out == 32'h05FA0004);
  endproperty
  a_sysrst_next: assert property (p_sysrst_next) else $error("no reset request after catch");
  property p_clear_late;
    $rose(dbg_req_out) && dbg_write_out && dbg_addr_out == `TGT_DEBUG_EXC_MON_CTRL_ADDR &&
      dbg_wdata_out == 32'h00000000 |-> !sticky_reg;
  endproperty
  a_clear_late: assert property (p_clear_late) else $error("catch cleared too early");
  property p_req_hold;
    dbg_req_out && !dbg_ack_in |=> dbg_req_out && $stable(dbg_addr_out) &&
      $stable(dbg_wdata_out) && $stable(dbg_write_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("debug request changed early");
  property p_div;
    busy_out && strat_reg == 4'h9 |-> swd_clk_div_out <= `SEQ_SWD_MAX_DIV;
  endproperty
  a_div: assert property (p_div) else $error("serial clock too slow");
  property p_wd_first;
    $rose(halted_out) && wd_st |-> wd_reg;
  endproperty
  a_wd_first: assert property (p_wd_first) else $error("halted before watchdog write");
  property p_unsupp;
    start && bad_st |=> !busy_out [*3] ##1 error_out;
  endproperty
  a_unsupp: assert property (p_unsupp) else $error("bad strategy not refused");
  property p_end;
    $fell(busy_out) |-> halted_out || error_out;
  endproperty
  a_end: assert property (p_end) else $error("run ended neither halted nor failed");
endmodule
bind debug_reset_seq debug_reset_seq_checker #(.POLL_LIMIT(POLL_LIMIT)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .dbg_req_out(dbg_req_out), .dbg_write_out(dbg_write_out),
  .dbg_addr_out(dbg_addr_out), .dbg_wdata_out(dbg_wdata_out), .dbg_ack_in(dbg_ack_in),
  .dbg_rdata_in(dbg_rdata_in), .target_reset_n_out(target_reset_n_out),
  .swd_clk_div_out(swd_clk_div_out), .busy_out(busy_out), .halted_out(halted_out),
  .error_out(error_out));

// file: target_dbg_model.sv
`timescale 1ns/100ps
`include "debug_reset_seq_regs.vh"
// =====================================================================
// Behavioural target: debug port answering with a set latency.
// =====================================================================
module target_dbg_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire req_in,
  input wire write_in,
  input wire [31:0] addr_in,
  input wire [31:0] wdata_in,
  input wire reset_n_in,
  input wire [3:0] lat_in,
  input wire stuck_in,
  output reg ack_out,
  output reg [31:0] rdata_out
);
  reg [3:0] wait_reg; // Cycles spent on the current access.
  reg catch_reg; // Core reset vector catch armed.
  reg halted_reg; // Core halted.
  reg pin_reg; // Reset pin was seen low.
  reg [2:0] rst_cnt_reg; // Status reads left before the reset sticky bit drops.
  wire sticky = !reset_n_in || rst_cnt_reg != 3'h0;
  // The port keeps answering under reset; stuck_in models a reset that never ends.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ack_out, catch_reg, halted_reg, pin_reg, wait_reg, rst_cnt_reg} <= 11'h000;
      rdata_out <= 32'h00000000;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // Read data is only valid with ack.
      if (!reset_n_in) begin
        pin_reg <= 1'b1;
      end else if (pin_reg) begin
        pin_reg <= 1'b0;
        halted_reg <= halted_reg | catch_reg;
      end
      if (req_in && !ack_out) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg >= lat_in) begin
          wait_reg <= 4'h0;
          ack_out <= 1'b1;
          if (write_in && addr_in == `TGT_DEBUG_EXC_MON_CTRL_ADDR) catch_reg <= wdata_in[0];
          if (write_in && addr_in == `TGT_HALT_CTRL_STATUS_ADDR) halted_reg <= 1'b1;
          if (write_in && addr_in == `TGT_APP_INT_RESET_CTRL_ADDR) begin
            rst_cnt_reg <= 3'h3;
            halted_reg <= 1'b0;
          end
          if (!write_in) begin
            rdata_out <= 32'h00000000;
            if (addr_in == `TGT_HALT_CTRL_STATUS_ADDR) begin
              rdata_out <= {6'h00, sticky, 7'h00, halted_reg, 17'h00000};
              if (rst_cnt_reg != 3'h0 && !stuck_in) begin
                rst_cnt_reg <= rst_cnt_reg - 3'h1;
                if (rst_cnt_reg == 3'h1) halted_reg <= halted_reg | catch_reg;
              end
            end
          end
        end
      end
    end
  end
endmodule

// file: debug_reset_seq_tb.sv
`timescale 1ns/100ps
`include "debug_reset_seq_regs.vh"
// =====================================================================
// Testbench: every strategy code, random latency and setup, corners.
// =====================================================================
module debug_reset_seq_tb;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, dbg_ack_in, stuck;
  logic dbg_req_out, dbg_write_out, target_reset_n_out, busy_out, halted_out, error_out;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, dbg_addr_out, dbg_wdata_out, dbg_rdata_in;
  logic [31:0] rd_val, hash, wda, wdd;
  logic [15:0] swd_clk_div_out;
  logic [3:0] lat;
  integer seed, err_total, total_checks, cyc, n, s;
  localparam logic [31:0] VC = `TGT_DEBUG_EXC_MON_CTRL_ADDR;
  localparam logic [31:0] AI = `TGT_APP_INT_RESET_CTRL_ADDR;
  localparam logic [31:0] HC = `TGT_HALT_CTRL_STATUS_ADDR;
  // Short poll limit so the stuck-target case ends quickly.
  debug_reset_seq #(.POLL_LIMIT(8)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dbg_req_out(dbg_req_out),
    .dbg_write_out(dbg_write_out), .dbg_addr_out(dbg_addr_out),
    .dbg_wdata_out(dbg_wdata_out), .dbg_ack_in(dbg_ack_in), .dbg_rdata_in(dbg_rdata_in),
    .target_reset_n_out(target_reset_n_out), .swd_clk_div_out(swd_clk_div_out),
    .busy_out(busy_out), .halted_out(halted_out), .error_out(error_out));
  target_dbg_model target (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(dbg_req_out),
    .write_in(dbg_write_out), .addr_in(dbg_addr_out), .wdata_in(dbg_wdata_out),
    .reset_n_in(target_reset_n_out), .lat_in(lat), .stuck_in(stuck), .ack_out(dbg_ack_in),
    .rdata_out(dbg_rdata_in));
  // Clock at 200 MHz.
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Ordered digest of completed debug writes, so order errors show too.
  function automatic logic [31:0] h(input logic [31:0] x, a, d);
    return x * 31 + (a ^ d);
  endfunction
  function automatic logic [31:0] exp_hash(input integer st);
    logic [31:0] x;
    x = 32'h00000000;
    if (st == 3) x = h(h(h(x, VC, 1), HC, 32'hA05F0003), VC, 0);
    else if (st == 4 || st == 7 || st == 9) x = h(h(x, AI, 32'h05FA0004), HC, 32'hA05F0003);
    else if (st inside {0, 5, 6, 8, 10}) x = h(h(h(x, VC, 1), AI, 32'h05FA0004), VC, 0);
    if (st inside {6, 9, 10}) x = h(x, wda, wdd);
    return x;
  endfunction
  always @(posedge clk_sys_in) begin
    if (dbg_req_out && dbg_ack_in && dbg_write_out) hash <= h(hash, dbg_addr_out, dbg_wdata_out);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
  endtask
  // One run: start, wait for idle, then compare status, writes and pin.
  task automatic run(input integer st, input logic [4:0] est, input logic [31:0] eh);
    lat <= 4'($random(seed) & 7);
    hash = 32'h00000000;
    wr(`SEQ_CTRL_OFFSET, {24'h0, 4'(st), 4'h1});
    repeat (4) @(posedge clk_sys_in);
    n = 0;
    while (busy_out !== 1'b0 && n < 20000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (busy_out !== 1'b0) err_total++;
    rd(`SEQ_STATUS_OFFSET);
    chk("status", {27'h0, est}, {27'h0, rd_val[4:0]});
    chk("writes", eh, hash);
    chk("pin", 32'h1, {31'h0, target_reset_n_out});
  endtask
  task report_and_stop;
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    seed = 32'he05dab85;
    {err_total, total_checks, cyc} = 0;
    {rst_n_in, reg_wr_in, reg_rd_in, stuck, lat, reg_addr_in} = 0;
    reg_wdata_in = 32'h00000000;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(`SEQ_BOOT_WAIT_OFFSET);
    chk("boot_wait", 32'h00000400, rd_val);
    rd(`SEQ_CLK_DIV_OFFSET);
    chk("clk_div", 32'h00000009, rd_val);
    rd(8'h20);
    chk("unmapped", 32'h00000000, rd_val);
    wr(`SEQ_BOOT_WAIT_OFFSET, 32'h8 + ($random(seed) & 32'hF));
    wr(`SEQ_CLK_DIV_OFFSET, 32'h000001F4);
    wda = 32'h40000000 | ($random(seed) & 32'hFFFC);
    wdd = $random(seed);
    wr(`SEQ_WD_ADDR_OFFSET, wda);
    wr(`SEQ_WD_DATA_OFFSET, wdd);
    rd(`SEQ_WD_DATA_OFFSET);
    chk("wd_data", wdd, rd_val);
    // Every strategy code, supported or refused, then random repeats.
    for (s = 0; s < 16; s++) run(s, (s == 1 || s == 2 || s > 10) ? 5'h0C : 5'h02, exp_hash(s));
    repeat (6) begin
      s = $random(seed) & 15;
      run(s, (s == 1 || s == 2 || s > 10) ? 5'h0C : 5'h02, exp_hash(s));
    end
    // Reset sticky never drops: the poll must give up with an error.
    stuck <= 1'b1;
    run(8, 5'h14, h(h(0, VC, 1), AI, 32'h05FA0004));
    stuck <= 1'b0;
    // Device reset in the middle of a connect-under-reset run.
    wr(`SEQ_CTRL_OFFSET, 32'h00000031);
    repeat (40) @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk("abort_pin", 32'h1, {31'h0, target_reset_n_out});
    chk("abort_busy", 32'h0, {31'h0, busy_out});
    rst_n_in <= 1'b1;
    run(3, 5'h02, exp_hash(3));
    report_and_stop;
  end
endmodule
